// *** pkg/ssdqp_params.svh ***
`ifndef SSDQP_PARAMS_SVH
`define SSDQP_PARAMS_SVH

// ----------------------------------------
// Instruction opcodes
// ----------------------------------------
`define SSDQP_OP_READ        8'h03
`define SSDQP_OP_WRITE       8'h02
`define SSDQP_OP_CFG_READ    8'h05
`define SSDQP_OP_CFG_WRITE   8'h01
`define SSDQP_OP_FOUR_BIT    8'h38
`define SSDQP_OP_TWO_BIT     8'h3b
`define SSDQP_OP_SINGLE_BIT  8'hff

// ----------------------------------------
// Sequence lengths
// ----------------------------------------
`define SSDQP_CMD_BITS       5'h08
`define SSDQP_ADDR_BITS      5'h18
`define SSDQP_BYTE_BITS      5'h08
`define SSDQP_DUMMY_DUAL     5'h04
`define SSDQP_DUMMY_QUAD     5'h02

// ----------------------------------------
// Array and pointer
// ----------------------------------------
`define SSDQP_AW             17
`define SSDQP_ADDR_TOP       17'h1ffff
`define SSDQP_PAGE_BITS      5

// ----------------------------------------
// Configuration register
// ----------------------------------------
`define SSDQP_CFG_RESET      8'h40
`define SSDQP_CFG_PAUSE_DIS  0
`define SSDQP_CFG_MODE_HI    7
`define SSDQP_CFG_MODE_LO    6
`define SSDQP_MODE_BYTE      2'h0
`define SSDQP_MODE_BURST     2'h1
`define SSDQP_MODE_PAGE      2'h2

// ----------------------------------------
// Pin reset image {cs_n, sck, io[3:0]}
// ----------------------------------------
`define SSDQP_PINS_RST       6'h28

`endif

// *** pkg/ssdqp_pkg.sv ***
package ssdqp_pkg;

  // ----------------------------------------
  // Bus width and sequence phase
  // ----------------------------------------
  typedef enum logic [1:0] {
    W_SINGLE,
    W_DUAL,
    W_QUAD
  } ssdqp_width_t;

  typedef enum logic [2:0] {
    PH_CMD,
    PH_ADDR,
    PH_DUMMY,
    PH_RDATA,
    PH_WDATA,
    PH_MRD,
    PH_MWR,
    PH_IGNORE
  } ssdqp_phase_t;

  // ----------------------------------------
  // Serial pin bundle
  // ----------------------------------------
  typedef struct packed {
    logic       cs_n;
    logic       sck;
    logic [3:0] io;
  } ssdqp_pins_t;

endpackage

// *** core/ssdqp_sync.sv ***
`timescale 1ns/1ps
`include "ssdqp_params.svh"

module ssdqp_sync
  import ssdqp_pkg::*;
(
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  // Pins
  input  wire ssdqp_pins_t i_pins,
  output ssdqp_pins_t      o_pins
);

  localparam int unsigned W = $bits(ssdqp_pins_t);
  localparam logic [W-1:0] RST = `SSDQP_PINS_RST;

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  // ----------------------------------------
  // Two-stage synchroniser per bit
  // ----------------------------------------
  for (genvar g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        s1_q[g] <= RST[g];
        s2_q[g] <= RST[g];
      end else begin
        s1_q[g] <= i_pins[g];
        s2_q[g] <= s1_q[g];
      end
    end
  end

  assign o_pins = s2_q;

endmodule

// *** core/ssdqp_array.sv ***
`timescale 1ns/1ps
`include "ssdqp_params.svh"

module ssdqp_array (
  // Clock
  input  wire logic                   i_ref_clk,
  // Write port
  input  wire logic                   i_we,
  input  wire logic [`SSDQP_AW-1:0]   i_waddr,
  input  wire logic [7:0]             i_wdata,
  // Read port
  input  wire logic [`SSDQP_AW-1:0]   i_raddr,
  output logic [7:0]                  o_rdata
);

  logic [7:0] mem_q [0:(2**`SSDQP_AW)-1];

  // ----------------------------------------
  // Storage, one-cycle read latency
  // ----------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_q[i_raddr];
  end

endmodule

// *** core/ssdqp_core.sv ***
`timescale 1ns/1ps
`include "ssdqp_params.svh"

module ssdqp_core
  import ssdqp_pkg::*;
(
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  // Serial pins
  input  wire logic        i_cs_n,
  input  wire logic        i_sck,
  input  wire logic [3:0]  i_mux_data_lines,
  output logic [3:0]       o_mux_data_lines,
  output logic [3:0]       o_mux_data_lines_oe_n,
  // Status
  output ssdqp_width_t     o_bus_width,
  output logic [7:0]       o_cfg_mode,
  output logic             o_paused
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  ssdqp_pins_t            pins_raw;
  ssdqp_pins_t            pins_s;
  ssdqp_width_t           wid_q;
  ssdqp_phase_t           phase_q;
  logic [7:0]             cfg_q;
  logic                   sck_prev_q;
  logic                   hold_q;
  logic                   is_rd_q;
  logic [4:0]             cnt_q;
  logic [4:0]             ocnt_q;
  logic [23:0]            sh_q;
  logic [7:0]             osh_q;
  logic [`SSDQP_AW-1:0]   ptr_q;
  logic                   drive_q;
  logic [3:0]             dout_q;
  logic [3:0]             oe_n_q;
  logic                   we_q;
  logic [`SSDQP_AW-1:0]   waddr_q;
  logic [7:0]             wdata_q;
  logic [7:0]             rdata;

  logic                   cs_n_s;
  logic                   sck_s;
  logic                   fall_raw;
  logic                   sck_rise;
  logic                   sck_fall;
  logic                   hold_req;
  logic [4:0]             step;
  logic [4:0]             dummy_n;
  logic [4:0]             cnt_nx;
  logic [23:0]            sh_nx;
  logic [7:0]             opcode;
  logic [1:0]             mode;
  logic                   shifting;
  logic                   cmd_done;
  logic                   addr_done;
  logic                   dummy_done;
  logic                   wr_done;
  logic                   mw_done;
  logic                   rd_fall;
  logic                   byte_last;
  logic                   rd_adv;
  logic [7:0]             out_byte;
  logic [3:0]             drive_mask;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [23:0] shift_in(input logic [23:0] sh, input logic [3:0] io,
                                           input ssdqp_width_t w);
    case (w)
      W_DUAL:  shift_in = {sh[21:0], io[1:0]};
      W_QUAD:  shift_in = {sh[19:0], io[3:0]};
      default: shift_in = {sh[22:0], io[0]};
    endcase
  endfunction

  function automatic logic [`SSDQP_AW-1:0] next_ptr(input logic [`SSDQP_AW-1:0] p,
                                                    input logic page);
    logic [`SSDQP_PAGE_BITS-1:0] lo;
    lo = p[`SSDQP_PAGE_BITS-1:0] + 1'b1;
    if (page) begin
      next_ptr = {p[`SSDQP_AW-1:`SSDQP_PAGE_BITS], lo};
    end else begin
      next_ptr = p + 1'b1;
    end
  endfunction

  // ----------------------------------------
  // Pin synchroniser and memory array
  // ----------------------------------------
  assign pins_raw = '{cs_n: i_cs_n, sck: i_sck, io: i_mux_data_lines};

  ssdqp_sync u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_pins    (pins_raw),
    .o_pins    (pins_s)
  );

  ssdqp_array u_array (
    .i_ref_clk (i_ref_clk),
    .i_we      (we_q),
    .i_waddr   (waddr_q),
    .i_wdata   (wdata_q),
    .i_raddr   (ptr_q),
    .o_rdata   (rdata)
  );

  // ----------------------------------------
  // Edge detection and pause request
  // ----------------------------------------
  assign cs_n_s   = pins_s.cs_n;
  assign sck_s    = pins_s.sck;
  assign fall_raw = ~sck_s & sck_prev_q & ~cs_n_s;
  assign sck_rise = sck_s & ~sck_prev_q & ~cs_n_s & ~hold_q;
  assign sck_fall = fall_raw & ~hold_q;
  assign hold_req = ~cs_n_s & (wid_q != W_QUAD)
                  & ~cfg_q[`SSDQP_CFG_PAUSE_DIS]
                  & ~pins_s.io[3];

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hold_q <= 1'b0;
    end else if (cs_n_s) begin
      hold_q <= 1'b0;
    end else if (hold_req && (!sck_s || fall_raw)) begin
      hold_q <= 1'b1;
    end else if (!hold_req && !sck_s) begin
      hold_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Sequence decode
  // ----------------------------------------
  always_comb begin
    case (wid_q)
      W_DUAL:  step = 5'h02;
      W_QUAD:  step = 5'h04;
      default: step = 5'h01;
    endcase
  end

  assign dummy_n    = (wid_q == W_QUAD) ? `SSDQP_DUMMY_QUAD : `SSDQP_DUMMY_DUAL;
  assign sh_nx      = shift_in(sh_q, pins_s.io, wid_q);
  assign cnt_nx     = cnt_q + step;
  assign opcode     = sh_nx[7:0];
  assign mode       = cfg_q[`SSDQP_CFG_MODE_HI:`SSDQP_CFG_MODE_LO];
  assign shifting   = (phase_q == PH_CMD) || (phase_q == PH_ADDR)
                   || (phase_q == PH_WDATA) || (phase_q == PH_MWR);
  assign cmd_done   = sck_rise && (phase_q == PH_CMD) && (cnt_nx == `SSDQP_CMD_BITS);
  assign addr_done  = sck_rise && (phase_q == PH_ADDR) && (cnt_nx == `SSDQP_ADDR_BITS);
  assign dummy_done = sck_rise && (phase_q == PH_DUMMY) && ((cnt_q + 5'h01) == dummy_n);
  assign wr_done    = sck_rise && (phase_q == PH_WDATA) && (cnt_nx == `SSDQP_BYTE_BITS);
  assign mw_done    = sck_rise && (phase_q == PH_MWR) && (cnt_nx == `SSDQP_BYTE_BITS);

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      phase_q <= PH_CMD;
    end else if (cs_n_s) begin
      phase_q <= PH_CMD;
    end else if (cmd_done) begin
      case (opcode)
        `SSDQP_OP_READ:      phase_q <= PH_ADDR;
        `SSDQP_OP_WRITE:     phase_q <= PH_ADDR;
        `SSDQP_OP_CFG_READ:  phase_q <= PH_MRD;
        `SSDQP_OP_CFG_WRITE: phase_q <= PH_MWR;
        default:             phase_q <= PH_IGNORE;
      endcase
    end else if (addr_done) begin
      if (!is_rd_q) begin
        phase_q <= PH_WDATA;
      end else if (wid_q == W_SINGLE) begin
        phase_q <= PH_RDATA;
      end else begin
        phase_q <= PH_DUMMY;
      end
    end else if (dummy_done) begin
      phase_q <= PH_RDATA;
    end else if (mw_done || ((wr_done || rd_adv) && mode == `SSDQP_MODE_BYTE)) begin
      phase_q <= PH_IGNORE;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      is_rd_q <= 1'b0;
    end else if (cmd_done) begin
      is_rd_q <= (opcode == `SSDQP_OP_READ);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q <= 5'h00;
      sh_q  <= 24'h000000;
    end else if (cs_n_s) begin
      cnt_q <= 5'h00;
    end else if (sck_rise && shifting) begin
      sh_q  <= sh_nx;
      cnt_q <= (cmd_done || addr_done || wr_done || mw_done) ? 5'h00 : cnt_nx;
    end else if (sck_rise && phase_q == PH_DUMMY) begin
      cnt_q <= dummy_done ? 5'h00 : cnt_q + 5'h01;
    end
  end

  // ----------------------------------------
  // Width and configuration
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wid_q <= W_SINGLE;
    end else if (cmd_done) begin
      case (opcode)
        `SSDQP_OP_FOUR_BIT:   wid_q <= W_QUAD;
        `SSDQP_OP_TWO_BIT:    wid_q <= W_DUAL;
        `SSDQP_OP_SINGLE_BIT: wid_q <= W_SINGLE;
        default:              wid_q <= wid_q;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_q <= `SSDQP_CFG_RESET;
    end else if (mw_done) begin
      cfg_q <= sh_nx[7:0];
    end
  end

  // ----------------------------------------
  // Address pointer and array writes
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ptr_q <= '0;
    end else if (addr_done) begin
      ptr_q <= sh_nx[`SSDQP_AW-1:0];
    end else if (wr_done) begin
      ptr_q <= next_ptr(ptr_q, mode == `SSDQP_MODE_PAGE);
    end else if (rd_adv) begin
      ptr_q <= next_ptr(ptr_q, 1'b0);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      we_q    <= 1'b0;
      waddr_q <= '0;
      wdata_q <= 8'h00;
    end else begin
      we_q    <= wr_done;
      waddr_q <= ptr_q;
      wdata_q <= sh_nx[7:0];
    end
  end

  // ----------------------------------------
  // Output shifter
  // ----------------------------------------
  assign rd_fall   = sck_fall && ((phase_q == PH_RDATA) || (phase_q == PH_MRD));
  assign byte_last = (ocnt_q + step) == `SSDQP_BYTE_BITS;
  assign rd_adv    = rd_fall && (phase_q == PH_RDATA) && byte_last;
  assign out_byte  = (ocnt_q != 5'h00) ? osh_q : (phase_q == PH_MRD) ? cfg_q : rdata;

  always_comb begin
    case (wid_q)
      W_DUAL:  drive_mask = 4'hc;
      W_QUAD:  drive_mask = 4'h0;
      default: drive_mask = 4'hd;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ocnt_q  <= 5'h00;
      osh_q   <= 8'h00;
      dout_q  <= 4'h0;
      drive_q <= 1'b0;
    end else if (cs_n_s) begin
      ocnt_q  <= 5'h00;
      drive_q <= 1'b0;
    end else if (rd_fall) begin
      drive_q <= 1'b1;
      ocnt_q  <= byte_last ? 5'h00 : ocnt_q + step;
      case (wid_q)
        W_DUAL: begin
          dout_q <= {2'b00, out_byte[7:6]};
          osh_q  <= {out_byte[5:0], 2'b00};
        end
        W_QUAD: begin
          dout_q <= out_byte[7:4];
          osh_q  <= {out_byte[3:0], 4'h0};
        end
        default: begin
          dout_q <= {2'b00, out_byte[7], 1'b0};
          osh_q  <= {out_byte[6:0], 1'b0};
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      oe_n_q <= 4'hf;
    end else if (cs_n_s || hold_req || hold_q || !drive_q) begin
      oe_n_q <= 4'hf;
    end else begin
      oe_n_q <= drive_mask;
    end
  end

  assign o_mux_data_lines      = dout_q;
  assign o_mux_data_lines_oe_n = oe_n_q;
  assign o_bus_width           = wid_q;
  assign o_cfg_mode            = cfg_q;
  assign o_paused              = hold_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  pause_float_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    hold_req |=> (o_mux_data_lines_oe_n == 4'hf))
    else $error("output driven during pause");

  quad_no_pause_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (wid_q == W_QUAD) && !hold_q |=> !hold_q)
    else $error("pause entered in four-bit mode");

  pause_defer_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    hold_req && sck_s && !fall_raw && !hold_q |=> !hold_q)
    else $error("pause taken while clock high");

  pause_resume_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    hold_q && !hold_req && !sck_s && !cs_n_s |=> !hold_q ##0 $stable(cnt_q))
    else $error("pause release lost position");

  deselect_idle_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    cs_n_s |=> (phase_q == PH_CMD) ##1 (o_mux_data_lines_oe_n == 4'hf))
    else $error("deselect did not end transfer");

  four_bit_cmd_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    cmd_done && (opcode == `SSDQP_OP_FOUR_BIT) |=> (o_bus_width == W_QUAD)
    ##1 ((o_bus_width == W_QUAD) || $past(cmd_done)))
    else $error("four-bit enable not taken");

  read_cmd_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    cmd_done && (opcode == `SSDQP_OP_READ) |=> (phase_q == PH_ADDR) && is_rd_q)
    else $error("read opcode not decoded");

  read_wrap_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    rd_adv && (ptr_q == `SSDQP_ADDR_TOP) |=> (ptr_q == '0))
    else $error("read pointer did not wrap");

  page_loop_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    wr_done && (mode == `SSDQP_MODE_PAGE)
    |=> (ptr_q[`SSDQP_AW-1:`SSDQP_PAGE_BITS] == $past(ptr_q[`SSDQP_AW-1:`SSDQP_PAGE_BITS])))
    else $error("page write left its page");

endmodule

// *** test/ssdqp_host.sv ***
`timescale 1ns/1ps

module ssdqp_host
  import ssdqp_pkg::*;
(
  // Clock
  input  wire logic       i_ref_clk,
  // Device side of the data lines
  input  wire logic [3:0] i_dev_lines,
  input  wire logic [3:0] i_dev_oe_n,
  // Pins toward the device
  output logic            o_cs_n,
  output logic            o_sck,
  output logic [3:0]      o_lines
);
  // ----------------------------------------
  // Line resolution
  // ----------------------------------------
  logic [3:0] drv;
  logic [3:0] res;
  logic       pause_n;
  int         w;

  assign res     = (i_dev_lines & ~i_dev_oe_n) | (drv & i_dev_oe_n);
  assign o_lines = {(w == 4) ? (res[3] & pause_n) : pause_n, res[2:0]};

  initial begin
    o_cs_n  = 1'b1;
    o_sck   = 1'b0;
    drv     = 4'h0;
    pause_n = 1'b1;
    w       = 1;
  end

  // ----------------------------------------
  // Host primitives
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  // Clock idles low, select held over the whole frame
  task automatic sel();
    @(posedge i_ref_clk);
    o_cs_n <= 1'b0;
    cyc(4);
  endtask

  task automatic desel();
    @(posedge i_ref_clk);
    o_sck <= 1'b0;
    cyc(6);
    o_cs_n <= 1'b1;
    cyc(6);
  endtask

  // Pause changes only while selected, release with clock low
  task automatic pin(input logic s, input logic p);
    @(posedge i_ref_clk);
    o_sck   <= s;
    pause_n <= p;
  endtask

  // One byte, most significant chunk first; released lines show inverse
  task automatic xfer(input logic [7:0] b, input bit rd, output logic [7:0] r);
    int         i;
    logic [3:0] m;
    logic [3:0] c;
    m = 4'((1 << w) - 1);
    r = 8'h00;
    for (i = 0; i < 8; i += w) begin
      c = 4'(b >> (8 - w - i));
      @(posedge i_ref_clk);
      o_sck <= 1'b0;
      drv   <= rd ? ~drv : (c & m);
      cyc(6);
      r = 8'((r << w) | ((w == 1) ? {3'h0, o_lines[1]} : (o_lines & m)));
      @(posedge i_ref_clk);
      o_sck <= 1'b1;
      cyc(6);
    end
  endtask
endmodule

// *** test/tb_ssdqp_core.sv ***
`timescale 1ns/1ps
`include "ssdqp_params.svh"

module tb_ssdqp_core
  import ssdqp_pkg::*;
;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic         i_ref_clk;
  logic         i_rstn;
  logic         cs_n;
  logic         sck;
  logic [3:0]   lines;
  logic [3:0]   dout;
  logic [3:0]   oe_n;
  ssdqp_width_t width;
  logic [7:0]   cfg_mode;
  logic         paused;
  logic [7:0]   r;
  int           fails;
  int           comparisons;
  int           cycles;

  ssdqp_core ssdqp_core_inst (
    .i_ref_clk            (i_ref_clk),
    .i_rstn               (i_rstn),
    .i_cs_n               (cs_n),
    .i_sck                (sck),
    .i_mux_data_lines     (lines),
    .o_mux_data_lines     (dout),
    .o_mux_data_lines_oe_n(oe_n),
    .o_bus_width          (width),
    .o_cfg_mode           (cfg_mode),
    .o_paused             (paused)
  );

  ssdqp_host ssdqp_host_inst (
    .i_ref_clk  (i_ref_clk),
    .i_dev_lines(dout),
    .i_dev_oe_n (oe_n),
    .o_cs_n     (cs_n),
    .o_sck      (sck),
    .o_lines    (lines)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end

  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      summarize();
    end
  end

  // ----------------------------------------
  // Checking and frame tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic hold(input bit hi);
    ssdqp_host_inst.pin(hi, 1'b1);
    ssdqp_host_inst.cyc(6);
    ssdqp_host_inst.pin(hi, 1'b0);
    ssdqp_host_inst.cyc(6);
    if (hi) begin
      check({paused, oe_n[1]}, 8'h01);
      ssdqp_host_inst.pin(1'b0, 1'b0);
      ssdqp_host_inst.cyc(6);
    end
    check({paused, oe_n[1]}, 8'h03);
    repeat (2) begin
      ssdqp_host_inst.pin(1'b1, 1'b0);
      ssdqp_host_inst.cyc(6);
      ssdqp_host_inst.pin(1'b0, 1'b0);
      ssdqp_host_inst.cyc(6);
    end
    ssdqp_host_inst.pin(1'b0, 1'b1);
    ssdqp_host_inst.cyc(6);
    check(paused, 8'h00);
  endtask

  // Opcode, 24 address bits, dummy byte in wide reads
  task automatic hdr(input logic [7:0] op, input logic [23:0] a, input bit dum);
    int i;
    ssdqp_host_inst.sel();
    ssdqp_host_inst.xfer(op, 1'b0, r);
    for (i = 0; i < 3; i++) ssdqp_host_inst.xfer(a[23-8*i -: 8], 1'b0, r);
    if (dum && ssdqp_host_inst.w > 1) ssdqp_host_inst.xfer(8'h00, 1'b1, r);
  endtask

  task automatic wr(input logic [23:0] a, input int n, input logic [23:0] d);
    int i;
    hdr(`SSDQP_OP_WRITE, a, 1'b0);
    for (i = 0; i < n; i++) ssdqp_host_inst.xfer(d[23-8*i -: 8], 1'b0, r);
    ssdqp_host_inst.desel();
  endtask

  task automatic rd(input logic [23:0] a, input int n, input logic [23:0] d,
                    input logic [3:0] oe, input int h);
    int i;
    hdr(`SSDQP_OP_READ, a, 1'b1);
    if (h > 0) hold(h == 2);
    for (i = 0; i < n; i++) begin
      ssdqp_host_inst.xfer(8'h00, 1'b1, r);
      check(r, d[23-8*i -: 8]);
    end
    check(oe_n, oe);
    ssdqp_host_inst.desel();
    check(oe_n, 8'h0f);
  endtask

  task automatic cmd(input logic [7:0] op, input logic [7:0] v, input int n);
    ssdqp_host_inst.sel();
    ssdqp_host_inst.xfer(op, 1'b0, r);
    if (op == `SSDQP_OP_CFG_WRITE) ssdqp_host_inst.xfer(v, 1'b0, r);
    repeat (n) begin
      ssdqp_host_inst.xfer(8'h00, 1'b1, r);
      check(r, v);
    end
    ssdqp_host_inst.desel();
  endtask

  task automatic nohold();
    ssdqp_host_inst.sel();
    ssdqp_host_inst.pin(1'b0, 1'b0);
    ssdqp_host_inst.cyc(8);
    check(paused, 8'h00);
    ssdqp_host_inst.pin(1'b0, 1'b1);
    ssdqp_host_inst.desel();
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    fails       = 0;
    comparisons = 0;
    cycles      = 0;
    i_rstn      = 1'b0;
    repeat (4) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    ssdqp_host_inst.cyc(2);
    check(8'(width), 8'(W_SINGLE));
    check(cfg_mode, `SSDQP_CFG_RESET);
    check({paused, oe_n}, 8'h0f);
    wr(24'hff_fffe, 3, 24'ha1b2c3);
    wr(24'h00_0100, 2, 24'h778800);
    rd(24'h81_fffe, 3, 24'ha1b2c3, 4'hd, 1);
    rd(24'h00_0100, 2, 24'h778800, 4'hd, 2);
    cmd(`SSDQP_OP_CFG_WRITE, 8'h81, 0);
    check(cfg_mode, 8'h81);
    cmd(`SSDQP_OP_CFG_READ, 8'h81, 2);
    nohold();
    wr(24'h00_003e, 3, 24'h112233);
    rd(24'h00_003e, 2, 24'h112200, 4'hd, 0);
    rd(24'h00_0020, 1, 24'h330000, 4'hd, 0);
    cmd(`SSDQP_OP_CFG_WRITE, 8'h00, 0);
    wr(24'h00_0100, 2, 24'h5a6b00);
    rd(24'h00_0100, 1, 24'h5a0000, 4'hd, 0);
    rd(24'h00_0101, 1, 24'h880000, 4'hd, 0);
    cmd(`SSDQP_OP_CFG_WRITE, 8'h40, 0);
    cmd(`SSDQP_OP_TWO_BIT, 8'h00, 0);
    ssdqp_host_inst.w = 2;
    check(8'(width), 8'(W_DUAL));
    wr(24'h00_0200, 2, 24'hc35a00);
    rd(24'h00_0200, 2, 24'hc35a00, 4'hc, 1);
    cmd(`SSDQP_OP_FOUR_BIT, 8'h00, 0);
    ssdqp_host_inst.w = 4;
    check(8'(width), 8'(W_QUAD));
    rd(24'h00_0200, 2, 24'hc35a00, 4'h0, 0);
    nohold();
    cmd(`SSDQP_OP_SINGLE_BIT, 8'h00, 0);
    ssdqp_host_inst.w = 1;
    check(8'(width), 8'(W_SINGLE));
    rd(24'h00_0200, 1, 24'hc30000, 4'hd, 0);
    summarize();
  end
endmodule
